// file: core/peak_trough_device.sv
// device end: dither period setting and peak/trough current readback
`timescale 1ns/1ps
`include "peak_trough_defs.svh"

module peak_trough_device
#(
    parameter int NCH   = 8,
    parameter int SUM_W = 20
)
(
    // clock and reset
    input  wire logic             REF_CLK,
    input  wire logic             RST_N,
    // serial link
    spi_link_if.device            LINK,
    // pwm period tick and per-period sample sums
    input  wire logic             PWM_TICK,
    input  wire logic             SUM_VALID,
    input  wire logic [2:0]       SUM_CHANNEL_SELECT,
    input  wire logic [SUM_W-1:0] SUM_DATA,
    // dither status per channel
    output logic [NCH-1:0]        DITHER_ON,
    output logic [NCH-1:0]        DITHER_END,
    // channel watched by the peak/trough readback
    output logic [2:0]            MON_CHANNEL_SELECT
);

    ////////////////////////////////////////////////////////////////////////
    // link state

    logic        sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic        cs_s1_r, cs_s2_r, cs_s3_r;
    logic        mosi_s1_r, mosi_s2_r;
    logic [31:0] rx_r, rx_nxt;
    logic [31:0] tx_r, tx_nxt;
    logic [5:0]  cnt_r, cnt_nxt;
    logic [31:0] pend_r, pend_nxt;
    logic        frame_done;

    always_comb
    begin
        rx_nxt  = rx_r;
        tx_nxt  = tx_r;
        cnt_nxt = cnt_r;
        if (~cs_s2_r & cs_s3_r)
        begin
            tx_nxt  = pend_r;
            cnt_nxt = 6'h00;
        end
        else if (!cs_s2_r)
        begin
            if (sclk_s2_r & ~sclk_s3_r)
            begin
                rx_nxt = {rx_r[30:0], mosi_s2_r};
                if (cnt_r != 6'h3f)
                    cnt_nxt = cnt_r + 6'h01;
            end
            if (~sclk_s2_r & sclk_s3_r)
                tx_nxt = {tx_r[30:0], 1'b0};
        end
    end

    // frames of any other length are dropped whole
    assign frame_done = cs_s2_r & ~cs_s3_r & (cnt_r == 6'(`FRAME_BITS));

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            cs_s3_r   <= 1'b1;
            mosi_s1_r <= 1'b0;
            mosi_s2_r <= 1'b0;
            rx_r      <= 32'h0000_0000;
            tx_r      <= 32'h0000_0000;
            cnt_r     <= 6'h00;
        end
        else
        begin
            sclk_s1_r <= LINK.sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            cs_s1_r   <= LINK.cs_n;
            cs_s2_r   <= cs_s1_r;
            cs_s3_r   <= cs_s2_r;
            mosi_s1_r <= LINK.mosi;
            mosi_s2_r <= mosi_s1_r;
            rx_r      <= rx_nxt;
            tx_r      <= tx_nxt;
            cnt_r     <= cnt_nxt;
        end
    end

    assign LINK.miso = tx_r[31];

    ////////////////////////////////////////////////////////////////////////
    // per-channel dither period counters

    logic [4:0]     steps_r [0:NCH-1];
    logic [4:0]     steps_nxt [0:NCH-1];
    logic [NCH-1:0] end_now;

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_channel_select
            logic [6:0] per_r, per_nxt;
            logic [6:0] period;

            assign period = 7'(steps_r[gi]) * `QUARTERS;

            always_comb
            begin
                per_nxt     = per_r;
                end_now[gi] = 1'b0;
                if (steps_r[gi] == 5'h00)
                    per_nxt = 7'h00;
                else if (PWM_TICK)
                begin
                    if (per_r >= period - 7'h01)
                    begin
                        per_nxt     = 7'h00;
                        end_now[gi] = 1'b1;
                    end
                    else
                        per_nxt = per_r + 7'h01;
                end
            end

            always_ff @(posedge REF_CLK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    per_r          <= 7'h00;
                    DITHER_ON[gi]  <= 1'b0;
                    DITHER_END[gi] <= 1'b0;
                end
                else
                begin
                    per_r          <= per_nxt;
                    DITHER_ON[gi]  <= (steps_r[gi] != 5'h00);
                    DITHER_END[gi] <= end_now[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // command decode, selection and peak/trough capture

    logic [2:0]       sel_r, sel_nxt;
    logic             armed_r, armed_nxt;
    logic             valid_r, valid_nxt;
    logic [SUM_W-1:0] acc_max_r, acc_max_nxt;
    logic [SUM_W-1:0] acc_min_r, acc_min_nxt;
    logic [10:0]      rep_max_r, rep_max_nxt;
    logic [10:0]      rep_min_r, rep_min_nxt;
    logic [3:0]       code;
    logic [2:0]       channel_select;
    logic             peak_rd;
    logic             chg;
    logic             end_sel;

    assign code    = rx_r[`CODE_MSB:`CODE_LSB];
    assign channel_select    = rx_r[`CHANNEL_SELECT_MSB:`CHANNEL_SELECT_LSB];
    assign peak_rd = frame_done && (code == `MSG_PEAK_TROUGH);
    assign chg     = peak_rd && (channel_select != sel_r);
    assign end_sel = end_now[sel_r];

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
            steps_nxt[i] = steps_r[i];
        pend_nxt    = pend_r;
        sel_nxt     = sel_r;
        armed_nxt   = armed_r;
        valid_nxt   = valid_r;
        acc_max_nxt = acc_max_r;
        acc_min_nxt = acc_min_r;
        rep_max_nxt = rep_max_r;
        rep_min_nxt = rep_min_r;
        if (frame_done)
            pend_nxt = {1'b0, code, channel_select, 24'h00_0000};
        if (frame_done && code == `MSG_DITHER_PERIOD)
        begin
            if (rx_r[`RW_BIT])
                steps_nxt[channel_select] = rx_r[`STEPS_MSB:0];
            // a read leaves the stored count alone
            pend_nxt[`STEPS_MSB:0] = rx_r[`RW_BIT] ?
                rx_r[`STEPS_MSB:0] : steps_r[channel_select];
        end
        if (peak_rd)
        begin
            pend_nxt[`VALID_BIT]  = valid_r;
            pend_nxt[21:11]       = rep_max_r;
            pend_nxt[10:0]        = rep_min_r;
            valid_nxt             = 1'b0;
            sel_nxt               = channel_select;
        end
        // a partly seen cycle after a channel change is thrown away,
        // which is why a new channel needs up to two cycles
        if (chg)
            armed_nxt = 1'b0;
        else if (end_sel)
            armed_nxt = 1'b1;
        if (end_sel && armed_r && !chg)
        begin
            rep_max_nxt = acc_max_r[SUM_W-1 -: `REPORT_BITS];
            rep_min_nxt = acc_min_r[SUM_W-1 -: `REPORT_BITS];
            valid_nxt   = 1'b1;
        end
        if (chg || end_sel)
        begin
            acc_max_nxt = '0;
            acc_min_nxt = '1;
        end
        if (SUM_VALID && SUM_CHANNEL_SELECT == sel_nxt)
        begin
            if (SUM_DATA > acc_max_nxt)
                acc_max_nxt = SUM_DATA;
            if (SUM_DATA < acc_min_nxt)
                acc_min_nxt = SUM_DATA;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int i = 0; i < NCH; i++)
                steps_r[i] <= `STEPS_RESET;
            pend_r    <= 32'h0000_0000;
            sel_r     <= 3'h0;
            armed_r   <= 1'b0;
            valid_r   <= 1'b0;
            acc_max_r <= '0;
            acc_min_r <= '1;
            rep_max_r <= `PEAK_RESET;
            rep_min_r <= `TROUGH_RESET;
            MON_CHANNEL_SELECT  <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
                steps_r[i] <= steps_nxt[i];
            pend_r    <= pend_nxt;
            sel_r     <= sel_nxt;
            armed_r   <= armed_nxt;
            valid_r   <= valid_nxt;
            acc_max_r <= acc_max_nxt;
            acc_min_r <= acc_min_nxt;
            rep_max_r <= rep_max_nxt;
            rep_min_r <= rep_min_nxt;
            MON_CHANNEL_SELECT  <= sel_nxt;
        end
    end

endmodule

// file: core/peak_trough_defs.svh
// offsets, field positions, reset values and timing counts for the link
`ifndef PEAK_TROUGH_DEFS_SVH
`define PEAK_TROUGH_DEFS_SVH

// frame layout
`define FRAME_BITS        32
`define RW_BIT            31
`define CODE_MSB          30
`define CODE_LSB          27
`define CHANNEL_SELECT_MSB          26
`define CHANNEL_SELECT_LSB          24
`define VALID_BIT         22
`define STEPS_MSB         4
`define REPORT_BITS       11

// message codes
`define MSG_DITHER_PERIOD 4'h4
`define MSG_PEAK_TROUGH   4'h5

// reset values
`define STEPS_RESET       5'h00
`define PEAK_RESET        11'h000
`define TROUGH_RESET      11'h7ff

// pwm periods per dither step count: four quarters
`define QUARTERS          7'h04

// host serial clock half period in REF_CLK cycles
`define SCLK_HALF_CYCLES  8

// host register offsets
`define OFS_COMMAND       8'h00
`define OFS_REPLY         8'h04
`define OFS_STATUS        8'h08
`define OFS_MASK          8'h0c

// host status bits
`define ST_BUSY           0
`define ST_DONE           1
`define ST_DROP           2

`endif

// file: core/peak_trough_pkg.sv
// types used by the host end of the link
package peak_trough_pkg;

    typedef enum logic [2:0]
    {
        H_IDLE,
        H_LOW,
        H_HIGH,
        H_TAIL,
        H_GAP
    } host_state_type;

endpackage

// file: core/spi_link_if.sv
// serial link between the host controller and the device
`timescale 1ns/1ps

interface spi_link_if;

    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;

    modport device
    (
        input  sclk,
        input  cs_n,
        input  mosi,
        output miso
    );

    modport host
    (
        output sclk,
        output cs_n,
        output mosi,
        input  miso
    );

endinterface

// file: core/peak_trough_host.sv
// host end: APB command registers driving the serial link
`timescale 1ns/1ps
`include "peak_trough_defs.svh"

module peak_trough_host
#(
    parameter int HALF = `SCLK_HALF_CYCLES
)
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // interrupt
    output logic             IRQ,
    // serial link
    spi_link_if.host         LINK
);

    peak_trough_pkg::host_state_type st_r, st_nxt;

    logic        m1_r, m2_r;
    logic        sclk_r, sclk_nxt;
    logic        cs_n_r, cs_n_nxt;
    logic [31:0] tx_r, tx_nxt;
    logic [31:0] rx_r, rx_nxt;
    logic [31:0] reply_r, reply_nxt;
    logic [4:0]  bit_r, bit_nxt;
    logic [7:0]  tm_r, tm_nxt;
    logic        done_r, done_nxt;
    logic        drop_r, drop_nxt;
    logic [2:0]  mask_r, mask_nxt;
    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        wr;
    logic        start;
    logic        tm_end;
    logic        fin;
    logic        busy;
    logic [2:0]  status;

    assign wr     = PSEL && PENABLE && PREADY && PWRITE;
    assign busy   = (st_r != peak_trough_pkg::H_IDLE);
    assign start  = wr && PADDR == `OFS_COMMAND && !busy;
    assign tm_end = (tm_r == 8'(HALF - 1));
    assign fin    = (st_r == peak_trough_pkg::H_TAIL) && tm_end;
    assign status = {drop_r, done_r, busy};

    ////////////////////////////////////////////////////////////////////////
    // link sequencer: mode 0, msb first, cs held one half after the end

    always_comb
    begin
        st_nxt    = st_r;
        sclk_nxt  = sclk_r;
        cs_n_nxt  = cs_n_r;
        tx_nxt    = tx_r;
        rx_nxt    = rx_r;
        reply_nxt = reply_r;
        bit_nxt   = bit_r;
        tm_nxt    = tm_end ? 8'h00 : tm_r + 8'h01;
        case (st_r)
            peak_trough_pkg::H_IDLE:
            begin
                tm_nxt = 8'h00;
                if (start)
                begin
                    tx_nxt   = PWDATA;
                    cs_n_nxt = 1'b0;
                    bit_nxt  = 5'h00;
                    st_nxt   = peak_trough_pkg::H_LOW;
                end
            end
            peak_trough_pkg::H_LOW:
                if (tm_end)
                begin
                    sclk_nxt = 1'b1;
                    rx_nxt   = {rx_r[30:0], m2_r};
                    st_nxt   = peak_trough_pkg::H_HIGH;
                end
            peak_trough_pkg::H_HIGH:
                if (tm_end)
                begin
                    sclk_nxt = 1'b0;
                    tx_nxt   = {tx_r[30:0], 1'b0};
                    bit_nxt  = bit_r + 5'h01;
                    st_nxt   = (bit_r == 5'h1f) ? peak_trough_pkg::H_TAIL
                                                : peak_trough_pkg::H_LOW;
                end
            peak_trough_pkg::H_TAIL:
                if (tm_end)
                begin
                    cs_n_nxt  = 1'b1;
                    reply_nxt = rx_r;
                    st_nxt    = peak_trough_pkg::H_GAP;
                end
            // gap lets the device build the reply before the next frame
            peak_trough_pkg::H_GAP:
                if (tm_end)
                    st_nxt = peak_trough_pkg::H_IDLE;
            default:
                st_nxt = peak_trough_pkg::H_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers, zero wait state

    always_comb
    begin
        done_nxt   = done_r;
        drop_nxt   = drop_r;
        mask_nxt   = mask_r;
        pready_nxt = PSEL && !PENABLE;
        prdata_nxt = 32'h0000_0000;
        if (wr && PADDR == `OFS_STATUS)
        begin
            if (PWDATA[`ST_DONE])
                done_nxt = 1'b0;
            if (PWDATA[`ST_DROP])
                drop_nxt = 1'b0;
        end
        if (wr && PADDR == `OFS_MASK)
            mask_nxt = PWDATA[2:0];
        // set beats a clear in the same cycle
        if (fin)
            done_nxt = 1'b1;
        if (wr && PADDR == `OFS_COMMAND && busy)
            drop_nxt = 1'b1;
        if (PSEL && !PENABLE && !PWRITE)
            case (PADDR)
                `OFS_REPLY:  prdata_nxt = reply_r;
                `OFS_STATUS: prdata_nxt = {29'h0000_0000, status};
                `OFS_MASK:   prdata_nxt = {29'h0000_0000, mask_r};
                default:     prdata_nxt = 32'h0000_0000;
            endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_r    <= peak_trough_pkg::H_IDLE;
            m1_r    <= 1'b0;
            m2_r    <= 1'b0;
            sclk_r  <= 1'b0;
            cs_n_r  <= 1'b1;
            tx_r    <= 32'h0000_0000;
            rx_r    <= 32'h0000_0000;
            reply_r <= 32'h0000_0000;
            bit_r   <= 5'h00;
            tm_r    <= 8'h00;
            done_r  <= 1'b0;
            drop_r  <= 1'b0;
            mask_r  <= 3'h0;
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            IRQ     <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            m1_r    <= LINK.miso;
            m2_r    <= m1_r;
            sclk_r  <= sclk_nxt;
            cs_n_r  <= cs_n_nxt;
            tx_r    <= tx_nxt;
            rx_r    <= rx_nxt;
            reply_r <= reply_nxt;
            bit_r   <= bit_nxt;
            tm_r    <= tm_nxt;
            done_r  <= done_nxt;
            drop_r  <= drop_nxt;
            mask_r  <= mask_nxt;
            PRDATA  <= prdata_nxt;
            PREADY  <= pready_nxt;
            PSLVERR <= 1'b0;
            IRQ     <= |({drop_nxt, done_nxt} & mask_nxt[2:1]);
        end
    end

    assign LINK.sclk = sclk_r;
    assign LINK.cs_n = cs_n_r;
    assign LINK.mosi = tx_r[31];

endmodule

// file: testbench/peak_trough_monitor.sv
// link checker: framing, timing and reply layout on the serial link
`timescale 1ns/1ps
`include "peak_trough_defs.svh"

module peak_trough_monitor
#(
    parameter int HALF = 8
)
(
    // clock and reset
    input  wire logic REF_CLK,
    input  wire logic RST_N,
    // serial link
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    input  wire logic miso
);

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////////////////
    // words as seen at each rising serial clock, kept until the frame ends
    logic        sclk_d_r;
    logic        cs_d_r;
    logic [7:0]  hi_r, hi_nxt;
    logic [5:0]  bits_r, bits_nxt;
    logic [31:0] mo_r, mo_nxt;
    logic [31:0] mi_r, mi_nxt;
    logic [31:0] cmd_r, cmd_nxt;
    logic        ok_r, ok_nxt;
    logic        fin;
    logic        prev;
    logic [3:0]  code;

    assign fin  = cs_n && !cs_d_r;
    // the reply in this frame answers the command of the last full frame
    assign prev = fin && ok_r;
    assign code = cmd_r[30:27];

    always_comb
    begin
        hi_nxt = sclk ? hi_r + 8'h01 : 8'h00;
        {bits_nxt, mo_nxt, mi_nxt} = {bits_r, mo_r, mi_r};
        {cmd_nxt, ok_nxt} = {cmd_r, ok_r};
        if (!cs_n && cs_d_r)
            bits_nxt = 6'h00;
        if (sclk && !sclk_d_r)
            {bits_nxt, mo_nxt, mi_nxt} = {bits_r + 6'h01,
                mo_r[30:0], mosi, mi_r[30:0], miso};
        if (fin)
            {cmd_nxt, ok_nxt} = {mo_r, bits_r == 6'h20};
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            {sclk_d_r, cs_d_r, hi_r, bits_r} <= {1'b0, 1'b1, 8'h00, 6'h00};
            {mo_r, mi_r, cmd_r, ok_r} <= '0;
        end
        else
        begin
            {sclk_d_r, cs_d_r, hi_r, bits_r} <= {sclk, cs_n, hi_nxt, bits_nxt};
            {mo_r, mi_r, cmd_r, ok_r} <= {mo_nxt, mi_nxt, cmd_nxt, ok_nxt};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_idle_low;
        cs_n |-> !sclk;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("serial clock high outside a frame");

    property p_first_edge;
        $fell(cs_n) |-> !sclk [*8] ##1 sclk;
    endproperty
    a_first_edge: assert property (p_first_edge)
        else $error("first serial clock edge misplaced");

    property p_sclk_high;
        $fell(sclk) |-> hi_r == HALF;
    endproperty
    a_sclk_high: assert property (p_sclk_high)
        else $error("serial clock high phase has wrong length");

    property p_gap;
        $rose(cs_n) |-> cs_n [*8];
    endproperty
    a_gap: assert property (p_gap)
        else $error("gap between frames too short");

    property p_mosi_hold;
        sclk && $past(sclk) |-> $stable(mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("command bit changed while serial clock high");

    property p_frame_bits;
        fin |-> bits_r == 6'h20;
    endproperty
    a_frame_bits: assert property (p_frame_bits)
        else $error("frame without 32 clock edges");

    property p_reply_period;
        prev && code == `MSG_DITHER_PERIOD
            |-> mi_r[31:5] == {1'b0, cmd_r[30:24], 19'h00000};
    endproperty
    a_reply_period: assert property (p_reply_period)
        else $error("dither period reply header wrong");

    property p_steps_echo;
        prev && code == `MSG_DITHER_PERIOD && cmd_r[31]
            |-> mi_r[4:0] == cmd_r[4:0];
    endproperty
    a_steps_echo: assert property (p_steps_echo)
        else $error("written step count not returned");

    property p_reply_peak;
        prev && code == `MSG_PEAK_TROUGH
            |-> mi_r[31:23] == {1'b0, cmd_r[30:24], 1'b0};
    endproperty
    a_reply_peak: assert property (p_reply_peak)
        else $error("peak trough reply header wrong");

    c_period: cover property (prev && code == `MSG_DITHER_PERIOD);
    c_peak: cover property (prev && code == `MSG_PEAK_TROUGH);
    c_write: cover property (prev && cmd_r[31]);

endmodule

// file: testbench/tb.sv
// bench: host and device ends joined over the link, driven through apb
`timescale 1ns/1ps
`include "peak_trough_defs.svh"

module tb;

    localparam logic [3:0] PER = `MSG_DITHER_PERIOD;
    localparam logic [3:0] PKT = `MSG_PEAK_TROUGH;

    logic        REF_CLK;
    logic        RST_N;
    logic        PSEL, PENABLE, PWRITE, PREADY, IRQ, PSLVERR;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic        PWM_TICK, SUM_VALID;
    logic [2:0]  SUM_CHANNEL_SELECT, MON_CHANNEL_SELECT;
    logic [19:0] SUM_DATA;
    logic [7:0]  DITHER_ON, DITHER_END;
    logic [3:0]  pcnt;
    logic        odd;
    int          n_errors = 0;
    int          total_checks = 0;

    spi_link_if link();

    peak_trough_host #(.HALF(8)) u_peak_trough_host
    (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .LINK(link)
    );

    peak_trough_device u_peak_trough_device
    (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .LINK(link), .PWM_TICK(PWM_TICK),
        .SUM_VALID(SUM_VALID), .SUM_CHANNEL_SELECT(SUM_CHANNEL_SELECT), .SUM_DATA(SUM_DATA),
        .DITHER_ON(DITHER_ON), .DITHER_END(DITHER_END), .MON_CHANNEL_SELECT(MON_CHANNEL_SELECT)
    );

    peak_trough_monitor #(.HALF(8)) u_peak_trough_monitor
    (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .sclk(link.sclk),
        .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso)
    );

    initial
    begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    ////////////////////////////////////////////////////////////////////////
    // one sum per channel each 16-cycle pwm period, channel in the top 3 bits, then a byte alternating
    // 0x10 and 0x30, so every dither cycle has a known peak and trough
    always @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            {PWM_TICK, SUM_VALID, SUM_CHANNEL_SELECT, SUM_DATA, pcnt, odd} <= '0;
        end
        else
        begin
            pcnt      <= pcnt + 4'h1;
            odd       <= (pcnt == 4'hf) ? !odd : odd;
            PWM_TICK  <= (pcnt == 4'hf);
            SUM_VALID <= !pcnt[3];
            SUM_CHANNEL_SELECT  <= pcnt[2:0];
            SUM_DATA  <= {pcnt[2:0], odd ? 8'h30 : 8'h10, 9'h000};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic fail_wait(input string what);
        chk(what, 32'h1, 32'h0);
        stop_test();
    endtask

    function automatic logic [31:0] msg(input logic rw, input logic [3:0] c,
                                        input logic [2:0] ch,
                                        input logic [4:0] v);
        return {rw, c, ch, 19'h00000, v};
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge REF_CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, wr, a, d};
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        k = 0;
        do
        begin
            @(posedge REF_CLK);
            k++;
        end
        while (PREADY !== 1'b1 && k < 20);
        q = PRDATA;
        {PSEL, PENABLE} <= 2'b00;
        if (PREADY !== 1'b1)
            fail_wait("apb ready");
    endtask

    // a new command while busy is dropped, so wait for idle too
    task automatic wait_done(output logic [31:0] s);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, `OFS_STATUS, 32'h0, s);
            k++;
        end
        while ((s[`ST_DONE] !== 1'b1 || s[`ST_BUSY] !== 1'b0) && k < 400);
        if (k >= 400)
            fail_wait("frame done");
    endtask

    // returns the reply to the command sent before this one
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] rep);
        logic [31:0] s;
        apb(1'b1, `OFS_COMMAND, cmd, s);
        wait_done(s);
        apb(1'b1, `OFS_STATUS, 32'h2, s);
        apb(1'b0, `OFS_REPLY, 32'h0, rep);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_state();
        logic [31:0] r;
        chk("irq", 32'h0, {31'h0, IRQ});
        apb(1'b1, 8'h10, 32'hffffffff, r);
        apb(1'b0, 8'h10, 32'h0, r);
        chk("unmapped", 32'h0, r);
        chk("pslverr", 32'h0, {31'h0, PSLVERR});
        xfer(msg(1'b0, PKT, 3'h0, 5'h00), r);
        xfer(msg(1'b0, PER, 3'h0, 5'h00), r);
        chk("peak reset", {1'b0, PKT, 5'h00, 11'h000, 11'h7ff},
            r);
        chk("dither on", 32'h0, {24'h0, DITHER_ON});
    endtask

    task automatic t_period();
        logic [31:0] r;
        xfer(msg(1'b1, PER, 3'h3, 5'h1f), r);
        chk("steps reset", msg(1'b0, PER, 3'h0, 5'h00), r);
        xfer(msg(1'b0, PER, 3'h3, 5'h00), r);
        chk("steps write", msg(1'b0, PER, 3'h3, 5'h1f), r);
        chk("dither on", 32'h8, {24'h0, DITHER_ON});
        xfer(msg(1'b1, PER, 3'h3, 5'h00), r);
        chk("steps read", msg(1'b0, PER, 3'h3, 5'h1f), r);
        xfer(msg(1'b0, PER, 3'h3, 5'h00), r);
        chk("steps zero", msg(1'b0, PER, 3'h3, 5'h00), r);
        chk("dither off", 32'h0, {24'h0, DITHER_ON});
    endtask

    // two steps: four quarters of two pwm periods of 16 cycles
    task automatic t_period_len();
        logic [31:0] r;
        int          n;
        xfer(msg(1'b1, PER, 3'h2, 5'h02), r);
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(posedge REF_CLK);
                n++;
            end
            while (DITHER_END[2] !== 1'b1 && n < 300);
            if (n >= 300)
                fail_wait("dither end");
        end
        chk("dither period", 32'h80, n);
    endtask

    task automatic t_minmax();
        logic [31:0] r;
        xfer(msg(1'b1, PER, 3'h1, 5'h01), r);
        xfer(msg(1'b0, PKT, 3'h1, 5'h00), r);
        chk("monitor channel_select", 32'h1, {29'h0, MON_CHANNEL_SELECT});
        xfer(msg(1'b0, PKT, 3'h1, 5'h00), r);
        xfer(msg(1'b0, PKT, 3'h4, 5'h00), r);
        // fields are the top 11 bits of the sums: channel number, then the byte
        chk("peak trough", {1'b0, PKT, 5'h05, 11'h130, 11'h110},
            r);
        chk("monitor channel_select", 32'h4, {29'h0, MON_CHANNEL_SELECT});
        xfer(msg(1'b0, PKT, 3'h4, 5'h00), r);
        xfer(msg(1'b0, PER, 3'h0, 5'h00), r);
        chk("valid", {23'h0, PKT, 5'h10}, {22'h0, r[31:22]});
    endtask

    task automatic t_irq();
        logic [31:0] s;
        apb(1'b1, `OFS_MASK, 32'h2, s);
        apb(1'b1, `OFS_COMMAND, msg(1'b0, PER, 3'h0, 5'h00), s);
        apb(1'b1, `OFS_COMMAND, msg(1'b0, PER, 3'h1, 5'h00), s);
        wait_done(s);
        chk("status", 32'h6, s);
        chk("irq done", 32'h1, {31'h0, IRQ});
        apb(1'b1, `OFS_STATUS, 32'h2, s);
        apb(1'b0, `OFS_STATUS, 32'h0, s);
        chk("status drop", 32'h4, s);
        chk("irq masked", 32'h0, {31'h0, IRQ});
        apb(1'b1, `OFS_STATUS, 32'h4, s);
        apb(1'b0, `OFS_STATUS, 32'h0, s);
        chk("status clear", 32'h0, s);
    endtask

    initial
    begin
        RST_N = 1'b0;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        repeat (16) @(posedge REF_CLK);
        RST_N <= 1'b1;
        t_reset_state();
        t_period();
        t_period_len();
        t_minmax();
        t_irq();
        stop_test();
    end

endmodule
